// *** design/pdhli_defines.svh ***
// Constants for the line interface: timing counts, substitution patterns, masks
`ifndef PDHLI_DEFINES_SVH
`define PDHLI_DEFINES_SVH
// System clock rate in MHz
`define PDHLI_CLK_MHZ 20
// Longest latency for alarm insertion or removal, in microseconds
`define PDHLI_ALARM_US 250
// Latency in system cycles, rounded down
`define PDHLI_ALARM_CYC (`PDHLI_ALARM_US * `PDHLI_CLK_MHZ)
// One second in system cycles
`define PDHLI_SEC_CYC 20000000
// Quiet bit periods before a signal loss is declared
`define PDHLI_QUIET_BITS 32
// Bits per monitored block
`define PDHLI_BLK_BITS 1024
// Link counter bit used as a heartbeat towards the system side
`define PDHLI_HB_BIT 3
// Slot codes of a substitution pattern: zero, bipolar mark, violation
`define PDHLI_SL_Z 2'h0
`define PDHLI_SL_B 2'h1
`define PDHLI_SL_V 2'h2
// Encoder patterns, first slot in bits 1:0
`define PDHLI_PAT_HDB3_ODD 16'h0080
`define PDHLI_PAT_HDB3_EVEN 16'h0081
`define PDHLI_PAT_B3ZS_ODD 16'h0020
`define PDHLI_PAT_B3ZS_EVEN 16'h0021
`define PDHLI_PAT_B6ZS 16'h0618
`define PDHLI_PAT_B8ZS 16'h6180
// Decoder signature, newest bit in bit 0
`define PDHLI_SIG_MARK 8'h1b
`define PDHLI_SIG_VIOL 8'h12
`define PDHLI_SIG_B6 8'h3f
`define PDHLI_SIG_B8 8'hff
`endif

// *** design/pdhli_pkg.sv ***
// Types shared by the line interface modules
package pdhli_pkg;
  // Operating rate
  typedef enum logic [2:0] {
    RATE_6M312, RATE_8M448, RATE_34M368, RATE_44M736, RATE_139M264
  } pdhli_rate_t;
  // Line code used on both directions
  typedef enum logic [2:0] {
    CODE_HDB3, CODE_B3ZS, CODE_B6ZS, CODE_B8ZS, CODE_CMI
  } pdhli_code_t;
  // Configuration from the equipment manager
  typedef struct packed {
    pdhli_rate_t rate;
    logic use_b8zs;
  } pdhli_cfg_t;
  // Per-second performance report
  typedef struct packed {
    logic [15:0] near_errored_block_count;
    logic [15:0] far_errored_block_count;
    logic near_defect_second;
    logic far_defect_second;
  } pdhli_pm_t;
endpackage : pdhli_pkg

// *** design/pdhli_encoder.sv ***
// Line encoder: bipolar zero substitution codes and coded mark inversion
`timescale 1ns/1ns
`include "pdhli_defines.svh"
module pdhli_encoder import pdhli_pkg::*; (
  // Link clock and reset
  input wire logic lclk_i,
  input wire logic lrst_n_i,
  // Control and data
  input wire pdhli_code_t code_i,
  input wire logic first_i,
  input wire logic data_i,
  // Line rails
  output logic pos_o,
  output logic neg_o
);
  logic [7:0] sr; // Look-ahead of incoming bits
  logic [15:0] pend; // Remaining substitution slots
  logic [2:0] pcnt; // Count of remaining slots
  logic last_pol, bpar, cmi_lvl, h2_pos;
  logic [3:0] len;
  logic [15:0] pat;
  logic zsub, mark, pol;
  logic [1:0] slot;
  // Window length and pattern for the current code
  always_comb begin
    len = 4'h1;
    pat = 16'h0000;
    case (code_i)
      CODE_HDB3: begin
        len = 4'h4;
        pat = bpar ? `PDHLI_PAT_HDB3_ODD : `PDHLI_PAT_HDB3_EVEN;
      end
      CODE_B3ZS: begin
        len = 4'h3;
        pat = bpar ? `PDHLI_PAT_B3ZS_ODD : `PDHLI_PAT_B3ZS_EVEN;
      end
      CODE_B6ZS: begin
        len = 4'h6;
        pat = `PDHLI_PAT_B6ZS;
      end
      CODE_B8ZS: begin
        len = 4'h8;
        pat = `PDHLI_PAT_B8ZS;
      end
      default: len = 4'h1;
    endcase
    zsub = code_i != CODE_CMI && pcnt == 3'h0 && (sr & (8'hff >> (4'h8 - len))) == 8'h00;
    if (pcnt != 3'h0) begin
      slot = pend[1:0];
    end else if (zsub) begin
      slot = pat[1:0];
    end else begin
      slot = sr[3'(len - 4'h1)] ? `PDHLI_SL_B : `PDHLI_SL_Z;
    end
    mark = slot != `PDHLI_SL_Z;
    // Violations repeat the last polarity
    pol = (slot == `PDHLI_SL_V) ? last_pol : ~last_pol;
  end
  // One symbol per bit, two half-bits per symbol
  always_ff @(posedge lclk_i) begin
    if (!lrst_n_i) begin
      sr <= 8'hff;
      pend <= 16'h0000;
      pcnt <= 3'h0;
      last_pol <= 1'b0;
      bpar <= 1'b0;
      cmi_lvl <= 1'b0;
      h2_pos <= 1'b0;
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else if (first_i) begin
      sr <= {sr[6:0], data_i};
      if (pcnt != 3'h0) begin
        pend <= pend >> 2;
        pcnt <= pcnt - 3'h1;
      end else if (zsub) begin
        pend <= pat >> 2;
        pcnt <= 3'(len - 4'h1);
      end
      if (code_i == CODE_CMI) begin
        cmi_lvl <= sr[0] ? ~cmi_lvl : cmi_lvl;
        pos_o <= sr[0] ? ~cmi_lvl : 1'b0;
        h2_pos <= sr[0] ? ~cmi_lvl : 1'b1;
        neg_o <= 1'b0;
      end else begin
        pos_o <= mark & pol;
        neg_o <= mark & ~pol;
        h2_pos <= 1'b0;
        if (mark) begin
          last_pol <= pol;
        end
        if (slot == `PDHLI_SL_V) begin
          bpar <= 1'b0;
        end else if (slot == `PDHLI_SL_B) begin
          bpar <= ~bpar;
        end
      end
    end else begin
      // Second half: return to zero, or CMI second level
      pos_o <= h2_pos;
      neg_o <= 1'b0;
    end
  end
endmodule : pdhli_encoder

// *** design/pdhli_decoder.sv ***
// Line decoder: half-bit alignment, code removal, violation flags
`timescale 1ns/1ns
`include "pdhli_defines.svh"
module pdhli_decoder import pdhli_pkg::*; (
  // Link clock and reset
  input wire logic lclk_i,
  input wire logic lrst_n_i,
  // Control and synchronised rails
  input wire pdhli_code_t code_i,
  input wire logic pos_i,
  input wire logic neg_i,
  // Decoded bit
  output logic stb_o,
  output logic bit_o,
  output logic act_o,
  output logic cv_o
);
  logic cur, prev, h1, h1_pos, rph, last_pol, last1;
  logic [7:0] wd, wm, wv; // Data, mark, violation windows
  logic align, cmi, mark, viol, bitv;
  logic [7:0] nd, nm, nv, sig;
  always_comb begin
    cmi = code_i == CODE_CMI;
    cur = cmi ? pos_i : (pos_i | neg_i);
    // Falling CMI edges lie only on bit edges; marks start a bit
    align = cmi ? (prev & ~cur) : (cur & ~prev);
    mark = h1;
    viol = ~cmi & mark & (h1_pos == last_pol);
    bitv = cmi ? (h1 == cur) : (mark & ~viol);
    nd = {wd[6:0], bitv};
    nm = {wm[6:0], mark};
    nv = {wv[6:0], viol};
    sig = (code_i == CODE_B6ZS) ? `PDHLI_SIG_B6 : `PDHLI_SIG_B8;
    if ((code_i == CODE_HDB3 || code_i == CODE_B3ZS) && viol) begin
      nd = nd & ((code_i == CODE_HDB3) ? 8'hf0 : 8'hf8);
      nv = 8'h00;
    end else if ((code_i == CODE_B6ZS || code_i == CODE_B8ZS)
                 && (nm & sig) == `PDHLI_SIG_MARK && (nv & sig) == `PDHLI_SIG_VIOL) begin
      nd = nd & ~sig;
      nv = 8'h00;
    end
  end
  // Free-running half-bit phase, pulled in by each alignment edge
  always_ff @(posedge lclk_i) begin
    if (!lrst_n_i) begin
      prev <= 1'b0;
      h1 <= 1'b0;
      h1_pos <= 1'b0;
      rph <= 1'b0;
      last_pol <= 1'b0;
      last1 <= 1'b0;
      wd <= 8'h00;
      wm <= 8'h00;
      wv <= 8'h00;
      stb_o <= 1'b0;
      bit_o <= 1'b0;
      act_o <= 1'b0;
      cv_o <= 1'b0;
    end else begin
      prev <= cur;
      stb_o <= 1'b0;
      if (rph && !align) begin
        rph <= 1'b0;
        stb_o <= 1'b1;
        wd <= nd;
        wm <= nm;
        wv <= nv;
        bit_o <= nd[7];
        if (cmi) begin
          act_o <= (h1 != cur) | (h1 != last1);
          cv_o <= (h1 & ~cur) | ((h1 == cur) & (h1 == last1));
          if (h1 == cur) begin
            last1 <= h1;
          end
        end else begin
          act_o <= mark;
          // A violation leaving the window unmatched is an error
          cv_o <= wv[7];
          if (mark) begin
            last_pol <= h1_pos;
          end
        end
      end else begin
        rph <= 1'b1;
        h1 <= cur;
        h1_pos <= pos_i;
      end
    end
  end
endmodule : pdhli_decoder

// *** design/pdhli_line_if.sv ***
// Line interface top: rate select, codec, signal loss, alarm stream, monitoring
//
// Notes on behaviour
// - HDB3 line code at 8448 and 34368
// - B3ZS line code at 44736
// - Coded mark inversion at 139264
// - Recover timing, decode, deliver data and clock
// - Detect signal loss at every rate
// - All-ones alarm within 250 us
// - Alarm timing stays within rate tolerance
// - Normal data again within 250 us
// - Report signal loss only when monitored
// - Per-second block counts and defect seconds
// - Deliver defect indications to management
// - B6ZS or B8ZS at 6312
`timescale 1ns/1ns
`include "pdhli_defines.svh"
module pdhli_line_if import pdhli_pkg::*; #(
  parameter int ALARM_CYC = `PDHLI_ALARM_CYC,
  parameter int SEC_CYC = `PDHLI_SEC_CYC,
  parameter int QUIET_BITS = `PDHLI_QUIET_BITS,
  parameter int BLK_BITS = `PDHLI_BLK_BITS
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link clock, twice the bit rate, free running locally
  input wire logic line_clk_i,
  // Configuration and supervision
  input wire pdhli_cfg_t cfg_i,
  input wire logic monitored_state_i,
  // Far-end indications from the path termination
  input wire logic far_block_err_i,
  input wire logic far_defect_i,
  // Transmit data from the path termination, link domain
  input wire logic tx_data_i,
  output logic tx_clk_o,
  // Line rails
  output logic tx_pos_o,
  output logic tx_neg_o,
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  // Receive data to the path termination, link domain
  output logic rx_data_o,
  output logic rx_clk_o,
  // Management outputs
  output logic signal_loss_defect_o,
  output pdhli_pm_t pm_o,
  output logic pm_valid_o
);

  //--------------------------------------------------------------
  // System side: code selection
  //--------------------------------------------------------------

  pdhli_code_t code_sys; // Code chosen from the rate

  // Map rate to line code
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      code_sys <= CODE_HDB3;
    end else begin
      case (cfg_i.rate)
        RATE_6M312: code_sys <= cfg_i.use_b8zs ? CODE_B8ZS : CODE_B6ZS;
        RATE_8M448: code_sys <= CODE_HDB3;
        RATE_34M368: code_sys <= CODE_HDB3;
        RATE_44M736: code_sys <= CODE_B3ZS;
        RATE_139M264: code_sys <= CODE_CMI;
        default: code_sys <= CODE_HDB3;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Link side: reset and configuration crossing
  //--------------------------------------------------------------

  logic [1:0] lrst_sync; // Reset release into the link domain
  logic lrst_n; // Link reset, active low
  logic [2:0] code_s1; // First stage, read only by the second
  logic [2:0] code_s2; // Second stage
  pdhli_code_t code_lnk; // Code seen by the codec

  // Reset synchroniser
  always_ff @(posedge line_clk_i) begin
    lrst_sync <= {lrst_sync[0], rst_n_i};
  end
  assign lrst_n = lrst_sync[1];

  // Code crossing; the code is quasi-static, so a torn value lasts one cycle
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      code_s1 <= 3'h0;
      code_s2 <= 3'h0;
    end else begin
      code_s1 <= code_sys;
      code_s2 <= code_s1;
    end
  end
  assign code_lnk = pdhli_code_t'(code_s2);

  //--------------------------------------------------------------
  // Link side: local bit timing
  //--------------------------------------------------------------

  logic [7:0] lcnt; // Link cycle counter, also the heartbeat

  // Local reference; tx_clk_o is low in the first half-bit
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      lcnt <= 8'h00;
      tx_clk_o <= 1'b0;
    end else begin
      lcnt <= lcnt + 8'h01;
      tx_clk_o <= ~tx_clk_o;
    end
  end

  //--------------------------------------------------------------
  // Transmit direction
  //--------------------------------------------------------------

  // Encoder takes a bit each time the local clock is low
  pdhli_encoder u_enc (
    .lclk_i(line_clk_i),
    .lrst_n_i(lrst_n),
    .code_i(code_lnk),
    .first_i(~tx_clk_o),
    .data_i(tx_data_i),
    .pos_o(tx_pos_o),
    .neg_o(tx_neg_o)
  );

  //--------------------------------------------------------------
  // Receive direction: pin synchronisers
  //--------------------------------------------------------------

  logic [1:0] rxp_sync; // Positive rail, two stages
  logic [1:0] rxn_sync; // Negative rail, two stages

  // Line pins are asynchronous to the local clock
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      rxp_sync <= 2'h0;
      rxn_sync <= 2'h0;
    end else begin
      rxp_sync <= {rxp_sync[0], rx_pos_i};
      rxn_sync <= {rxn_sync[0], rx_neg_i};
    end
  end

  logic dec_stb; // Decoded bit strobe
  logic dec_bit; // Decoded bit
  logic dec_act; // Line activity in that bit
  logic dec_cv; // Code violation in that bit

  pdhli_decoder u_dec (
    .lclk_i(line_clk_i),
    .lrst_n_i(lrst_n),
    .code_i(code_lnk),
    .pos_i(rxp_sync[1]),
    .neg_i(rxn_sync[1]),
    .stb_o(dec_stb),
    .bit_o(dec_bit),
    .act_o(dec_act),
    .cv_o(dec_cv)
  );

  //--------------------------------------------------------------
  // Receive direction: signal loss and alarm stream
  //--------------------------------------------------------------

  logic [15:0] quiet; // Bit periods without activity
  logic loss_lnk; // Signal loss, link domain

  // Count quiet bits; the decoder free-wheels, so bits keep coming
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      quiet <= 16'h0000;
      loss_lnk <= 1'b0;
    end else if (dec_stb) begin
      if (dec_act) begin
        quiet <= 16'h0000;
        loss_lnk <= 1'b0;
      end else if (quiet != 16'(QUIET_BITS - 1)) begin
        quiet <= quiet + 16'h0001;
      end else begin
        loss_lnk <= 1'b1;
      end
    end
  end

  // Deliver data and clock; under loss switch to ones on local timing
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      rx_data_o <= 1'b1;
      rx_clk_o <= 1'b0;
    end else if (loss_lnk) begin
      rx_data_o <= 1'b1;
      rx_clk_o <= ~tx_clk_o;
    end else if (dec_stb) begin
      rx_data_o <= dec_bit;
      rx_clk_o <= 1'b0;
    end else begin
      rx_clk_o <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Receive direction: errored blocks
  //--------------------------------------------------------------

  logic [15:0] blk_bits; // Bits in the current block
  logic blk_err; // Block has an error so far
  logic blk_tog; // Toggles once per errored block

  // Close a block every BLK_BITS bits
  always_ff @(posedge line_clk_i) begin
    if (!lrst_n) begin
      blk_bits <= 16'h0000;
      blk_err <= 1'b0;
      blk_tog <= 1'b0;
    end else if (dec_stb) begin
      if (blk_bits == 16'(BLK_BITS - 1)) begin
        blk_bits <= 16'h0000;
        blk_err <= 1'b0;
        if (blk_err || dec_cv) begin
          blk_tog <= ~blk_tog;
        end
      end else begin
        blk_bits <= blk_bits + 16'h0001;
        blk_err <= blk_err | dec_cv;
      end
    end
  end

  //--------------------------------------------------------------
  // System side: crossings from the link
  //--------------------------------------------------------------

  logic [1:0] loss_sync; // Loss level, two stages
  logic [2:0] blk_sync; // Block toggle, two stages and a history
  logic [2:0] hb_sync; // Heartbeat, two stages and a history
  logic blk_ev; // One errored block, system pulse

  // Levels and toggles pass two flip-flops before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      loss_sync <= 2'h0;
      blk_sync <= 3'h0;
      hb_sync <= 3'h0;
    end else begin
      loss_sync <= {loss_sync[0], loss_lnk};
      blk_sync <= {blk_sync[1:0], blk_tog};
      hb_sync <= {hb_sync[1:0], lcnt[`PDHLI_HB_BIT]};
    end
  end
  assign blk_ev = blk_sync[2] ^ blk_sync[1];

  //--------------------------------------------------------------
  // System side: link clock watchdog
  //--------------------------------------------------------------

  logic [31:0] hb_quiet; // System cycles since the heartbeat moved
  logic clk_dead; // Link clock has stopped

  // A dead link clock freezes the loss detector, so catch it here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hb_quiet <= 32'h0000_0000;
      clk_dead <= 1'b0;
    end else if (hb_sync[2] != hb_sync[1]) begin
      hb_quiet <= 32'h0000_0000;
      clk_dead <= 1'b0;
    end else if (hb_quiet != 32'(ALARM_CYC - 1)) begin
      hb_quiet <= hb_quiet + 32'h0000_0001;
    end else begin
      clk_dead <= 1'b1;
    end
  end

  logic loss_sys; // Loss as seen by management
  assign loss_sys = loss_sync[1] | clk_dead;

  // Defect report follows the supervision state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      signal_loss_defect_o <= 1'b0;
    end else begin
      signal_loss_defect_o <= monitored_state_i & loss_sys;
    end
  end

  //--------------------------------------------------------------
  // System side: one second performance window
  //--------------------------------------------------------------

  logic [31:0] sec_cnt; // Cycles into the current second
  logic sec_end; // Last cycle of the second
  logic [15:0] near_cnt; // Errored near blocks so far
  logic [15:0] far_cnt; // Errored far blocks so far
  logic near_ds; // Near defect seen this second
  logic far_ds; // Far defect seen this second
  logic [15:0] next_near; // Count including this cycle
  logic [15:0] next_far; // Count including this cycle

  assign sec_end = sec_cnt == 32'(SEC_CYC - 1);

  // Saturating counts; an event in the last cycle still counts
  always_comb begin
    next_near = near_cnt;
    next_far = far_cnt;
    if (blk_ev && near_cnt != 16'hffff) begin
      next_near = near_cnt + 16'h0001;
    end
    if (far_block_err_i && far_cnt != 16'hffff) begin
      next_far = far_cnt + 16'h0001;
    end
  end

  // Second timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sec_cnt <= 32'h0000_0000;
    end else if (sec_end) begin
      sec_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      near_cnt <= 16'h0000;
      far_cnt <= 16'h0000;
      near_ds <= 1'b0;
      far_ds <= 1'b0;
    end else if (sec_end) begin
      near_cnt <= 16'h0000;
      far_cnt <= 16'h0000;
      near_ds <= 1'b0;
      far_ds <= 1'b0;
    end else begin
      near_cnt <= next_near;
      far_cnt <= next_far;
      near_ds <= near_ds | loss_sys;
      far_ds <= far_ds | far_defect_i;
    end
  end

  // Report at the end of each second, only when monitored
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pm_o <= '0;
      pm_valid_o <= 1'b0;
    end else begin
      pm_valid_o <= 1'b0;
      if (sec_end && monitored_state_i) begin
        pm_o.near_errored_block_count <= next_near;
        pm_o.far_errored_block_count <= next_far;
        pm_o.near_defect_second <= near_ds | loss_sys;
        pm_o.far_defect_second <= far_ds | far_defect_i;
        pm_valid_o <= 1'b1;
      end
    end
  end

endmodule : pdhli_line_if

// *** bench/pdhli_line_chk.sv ***
// Assertions on the line interface top ports
`timescale 1ns/1ns
module pdhli_line_chk import pdhli_pkg::*; (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line_clk_i,
  // Control
  input wire pdhli_cfg_t cfg_i,
  input wire logic monitored_state_i,
  // Watched outputs
  input wire logic tx_clk_o,
  input wire logic tx_pos_o,
  input wire logic tx_neg_o,
  input wire logic signal_loss_defect_o,
  input wire pdhli_pm_t pm_o,
  input wire logic pm_valid_o
);
  // ----------------------------------------
  // Link side
  // ----------------------------------------
  property p_rails;
    @(posedge line_clk_i) disable iff (!rst_n_i) !(tx_pos_o && tx_neg_o);
  endproperty
  a_rails: assert property (p_rails) else $error("both rails high");
  // Depth of 30 lets a rate change drain the encoder pipeline
  property p_cmi;
    @(posedge line_clk_i) disable iff (!rst_n_i)
      cfg_i.rate == RATE_139M264 && $past(cfg_i.rate, 30) == RATE_139M264 |-> !tx_neg_o;
  endproperty
  a_cmi: assert property (p_cmi) else $error("negative rail used in mark inversion");
  // Link logic leaves reset two edges late, hence the depth of 4
  property p_txclk;
    @(posedge line_clk_i) disable iff (!rst_n_i)
      $past(rst_n_i, 4) |-> tx_clk_o != $past(tx_clk_o);
  endproperty
  a_txclk: assert property (p_txclk) else $error("bit clock missed a toggle");
  // ----------------------------------------
  // System side
  // ----------------------------------------
  property p_pm_one;
    @(posedge clk_i) disable iff (!rst_n_i) pm_valid_o |=> !pm_valid_o [*8];
  endproperty
  a_pm_one: assert property (p_pm_one) else $error("report pulse too long");
  property p_pm_mon;
    @(posedge clk_i) disable iff (!rst_n_i) pm_valid_o |-> $past(monitored_state_i);
  endproperty
  a_pm_mon: assert property (p_pm_mon) else $error("report while unmonitored");
  property p_loss_off;
    @(posedge clk_i) disable iff (!rst_n_i) !monitored_state_i [*6] |-> !signal_loss_defect_o;
  endproperty
  a_loss_off: assert property (p_loss_off) else $error("loss flagged while unmonitored");
  property p_pm_hold;
    @(posedge clk_i) disable iff (!rst_n_i) !pm_valid_o |-> $stable(pm_o);
  endproperty
  a_pm_hold: assert property (p_pm_hold) else $error("report moved between seconds");
  property p_rst;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !signal_loss_defect_o && !pm_valid_o && pm_o == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("management outputs not cleared");
endmodule : pdhli_line_chk

bind pdhli_line_if pdhli_line_chk pdhli_line_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .line_clk_i(line_clk_i), .cfg_i(cfg_i), .monitored_state_i(monitored_state_i),
  .tx_clk_o(tx_clk_o), .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o),
  .signal_loss_defect_o(signal_loss_defect_o), .pm_o(pm_o), .pm_valid_o(pm_valid_o));

// *** bench/pdhli_line_model.sv ***
// Far-end equipment: loops transmit rails back over a cable that can be cut
`timescale 1ns/1ns
module pdhli_line_model (
  // Link clock
  input wire logic line_clk_i,
  // Rails from the block and cable cut
  input wire logic pos_i,
  input wire logic neg_i,
  input wire logic cut_i,
  // Rails into the block
  output logic pos_o,
  output logic neg_o
);
  // One cycle of cable delay; a cut line is terminated, so it reads 0
  always @(posedge line_clk_i) begin
    pos_o <= #1 pos_i && !cut_i;
    neg_o <= #1 neg_i && !cut_i;
  end
endmodule : pdhli_line_model

// *** bench/pdhli_line_interface_tb_top.sv ***
// Self-checking bench for the line interface
`timescale 1ns/1ns
module pdhli_line_interface_tb_top;
  import pdhli_pkg::*;
  // Shortened counts keep the run brief
  localparam int ALARM = 50;
  localparam int SEC = 200;
  logic clk_i = 0, rst_n_i = 0, line_clk_i = 0;
  pdhli_cfg_t cfg = '0;
  logic monitored = 1, fbe = 0, fdef = 0, tx_data = 0, cut = 0, seen = 0;
  logic tx_clk, tx_pos, tx_neg, rx_pos, rx_neg, rx_data, rx_clk, loss, pm_valid;
  pdhli_pm_t pm;
  int fail_count = 0, check_count = 0;
  // ----------------------------------------
  // Clocks, design, far end
  // ----------------------------------------
  initial forever #25 clk_i = ~clk_i;
  // Link clock phase is unrelated to the system clock
  initial begin
    #3;
    forever #6 line_clk_i = ~line_clk_i;
  end
  pdhli_line_if #(.ALARM_CYC(ALARM), .SEC_CYC(SEC), .QUIET_BITS(8), .BLK_BITS(16))
  pdhli_line_if_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .line_clk_i(line_clk_i), .cfg_i(cfg),
    .monitored_state_i(monitored), .far_block_err_i(fbe), .far_defect_i(fdef),
    .tx_data_i(tx_data), .tx_clk_o(tx_clk), .tx_pos_o(tx_pos), .tx_neg_o(tx_neg),
    .rx_pos_i(rx_pos), .rx_neg_i(rx_neg), .rx_data_o(rx_data), .rx_clk_o(rx_clk),
    .signal_loss_defect_o(loss), .pm_o(pm), .pm_valid_o(pm_valid));
  pdhli_line_model pdhli_line_model_i (.line_clk_i(line_clk_i), .pos_i(tx_pos),
    .neg_i(tx_neg), .cut_i(cut), .pos_o(rx_pos), .neg_o(rx_neg));
  // Any mark on the line since last cleared
  always @(posedge line_clk_i) if (tx_pos || tx_neg) seen <= 1;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(string name, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  task tick(int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  task lt(int n);
    repeat (n) @(posedge line_clk_i);
    #2;
  endtask : lt
  // Data is settled at the rising recovered clock
  task rxbit(logic e, string n);
    @(posedge rx_clk);
    #1;
    chk(n, rx_data, e);
  endtask : rxbit
  // Wait a bounded time for the loss flag to reach a level
  task wloss(logic e);
    for (int n = 0; n < ALARM && loss !== e; n++) tick(1);
  endtask : wloss
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every rate and code: zeros must still put marks on the line
  task t_codes;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      cfg.rate = (i < 2) ? RATE_6M312 : pdhli_rate_t'(i - 1);
      cfg.use_b8zs = (i == 1);
      for (int d = 0; d < 2; d++) begin
        tx_data = d[0];
        lt(200);
        seen = 0;
        lt(40);
        chk("line marks", seen, 1);
        repeat (4) rxbit(d[0], "looped data");
        chk("loss on live line", loss, 0);
      end
    end
  endtask : t_codes
  // Cut cable, restore, then cut again while unmonitored
  task t_loss;
    int n;
    tx_data = 0;
    cut = 1;
    wloss(1);
    chk("loss set", loss, 1);
    repeat (3) rxbit(1, "alarm data");
    cut = 0;
    wloss(0);
    chk("loss cleared", loss, 0);
    lt(40);
    rxbit(0, "data after loss");
    monitored = 0;
    cut = 1;
    n = 0;
    repeat (SEC + 50) begin
      tick(1);
      n += (pm_valid === 1);
    end
    chk("unmonitored loss", loss, 0);
    chk("unmonitored reports", n, 0);
    rxbit(1, "unmonitored alarm");
    cut = 0;
    monitored = 1;
  endtask : t_loss
  // Far-end events counted into one second
  task t_pm;
    lt(40);
    for (int n = 0; n < SEC + 10 && pm_valid !== 1; n++) tick(1);
    repeat (3) begin
      fbe = 1;
      tick(1);
      fbe = 0;
      tick(2);
    end
    fdef = 1;
    tick(1);
    fdef = 0;
    for (int n = 0; n < SEC + 10 && pm_valid !== 1; n++) tick(1);
    chk("report pulse", pm_valid, 1);
    chk("far blocks", pm.far_errored_block_count, 3);
    chk("far second", pm.far_defect_second, 1);
    chk("near blocks", pm.near_errored_block_count, 0);
    chk("near second", pm.near_defect_second, 0);
  endtask : t_pm
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Run needs about 70 us; over five times that means a hang
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    tick(5);
    chk("loss in reset", loss, 0);
    chk("report in reset", pm_valid, 0);
    rst_n_i = 1;
    lt(4);
    t_codes();
    t_loss();
    t_pm();
    conclude();
  end
endmodule : pdhli_line_interface_tb_top
